/* hdl/kio_ctrl_regs.sv */
`timescale 1ns/1ps
`include "kio_map.svh"
module kio_ctrl_regs
  import kio_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register-file access
  input wire logic [5:0] i_rf_addr,
  input wire logic i_rf_wr,
  input wire logic i_rf_rd,
  input wire logic [3:0] i_rf_wdata,
  output logic [3:0] o_rf_rdata,
  output logic o_rf_rvalid,
  // current settings
  output logic [3:0] o_pb_dir,
  output logic [3:0] o_pe_dir,
  output logic [3:0] o_pe_pu,
  output logic [1:0] o_cd_grp,
  // settings as they will be after this edge
  output logic [3:0] o_pb_dir_nxt,
  output logic [3:0] o_pe_dir_nxt,
  output logic [3:0] o_pe_pu_nxt,
  output logic [1:0] o_cd_grp_nxt
);

  kio_rf_state_t st_ff;
  kio_rf_state_t nxt_st;

  // =====================================================================
  // decode; unused locations store nothing and read back the filler value
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (i_rf_wr)
    begin
      if (i_rf_addr == `KIO_RF_PE_PU)
        nxt_st.pe_pu = i_rf_wdata;
      else if (i_rf_addr == `KIO_RF_PB_DIR)
        nxt_st.pb_dir = i_rf_wdata;
      else if (i_rf_addr == `KIO_RF_PE_DIR)
        nxt_st.pe_dir = i_rf_wdata;
      else if (i_rf_addr == `KIO_RF_CD_GRP)
        nxt_st.cd_grp = {i_rf_wdata[`KIO_CD_GRP_D_BIT], i_rf_wdata[`KIO_CD_GRP_C_BIT]};
    end
    if (i_rf_rd)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = `KIO_UNUSED_RDATA;
      if (i_rf_addr == `KIO_RF_PE_PU)
        nxt_st.rdata = st_ff.pe_pu;
      else if (i_rf_addr == `KIO_RF_PB_DIR)
        nxt_st.rdata = st_ff.pb_dir;
      else if (i_rf_addr == `KIO_RF_PE_DIR)
        nxt_st.rdata = st_ff.pe_dir;
      else if (i_rf_addr == `KIO_RF_CD_GRP)
      begin
        nxt_st.rdata[`KIO_CD_GRP_C_BIT] = st_ff.cd_grp[0];
        nxt_st.rdata[`KIO_CD_GRP_D_BIT] = st_ff.cd_grp[1];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_ff <= '{pb_dir: `KIO_RST_PB_DIR, pe_dir: `KIO_RST_PE_DIR, pe_pu: `KIO_RST_PE_PU,
                 cd_grp: `KIO_RST_CD_GRP, rdata: 4'h0, rvalid: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign o_rf_rdata = st_ff.rdata;
  assign o_rf_rvalid = st_ff.rvalid;
  assign o_pb_dir = st_ff.pb_dir;
  assign o_pe_dir = st_ff.pe_dir;
  assign o_pe_pu = st_ff.pe_pu;
  assign o_cd_grp = st_ff.cd_grp;
  assign o_pb_dir_nxt = nxt_st.pb_dir;
  assign o_pe_dir_nxt = nxt_st.pe_dir;
  assign o_pe_pu_nxt = nxt_st.pe_pu;
  assign o_cd_grp_nxt = nxt_st.cd_grp;

endmodule

/* hdl/kio_map.svh */
`ifndef KIO_MAP_SVH
`define KIO_MAP_SVH

// =====================================================================
// control registers, reached by the register-file read/write instructions
`define KIO_RF_PE_PU 6'h17
`define KIO_RF_PB_DIR 6'h26
`define KIO_RF_PE_DIR 6'h27
`define KIO_RF_CD_GRP 6'h37
`define KIO_CD_GRP_C_BIT 2
`define KIO_CD_GRP_D_BIT 3

// =====================================================================
// port registers in data memory (bank select is a separate port)
`define KIO_PR_PE 7'h6F
`define KIO_PR_PA 7'h70
`define KIO_PR_PF 7'h70
`define KIO_PR_PB 7'h71
`define KIO_PR_PC 7'h72
`define KIO_PR_PD 7'h73

// =====================================================================
// reset values
`define KIO_RST_PB_DIR 4'h0
`define KIO_RST_PE_DIR 4'h0
`define KIO_RST_PE_PU 4'h0
`define KIO_RST_CD_GRP 2'h3
`define KIO_RST_PB_LAT 4'hF
`define KIO_RST_PC_LAT 4'h0
`define KIO_RST_PD_LAT 4'h0
`define KIO_RST_PE_LAT 4'hF
`define KIO_RST_PF_LAT 1'h1
`define KIO_UNUSED_RDATA 4'h0

`endif

/* hdl/kio_pkg.sv */
package kio_pkg;

  // =====================================================================
  // control register state
  typedef struct packed {
    logic [3:0] pb_dir;
    logic [3:0] pe_dir;
    logic [3:0] pe_pu;
    logic [1:0] cd_grp;
    logic [3:0] rdata;
    logic rvalid;
  } kio_rf_state_t;

  // =====================================================================
  // port latches, read path and registered pin drive
  typedef struct packed {
    logic [3:0] pb_lat;
    logic [3:0] pc_lat;
    logic [3:0] pd_lat;
    logic [3:0] pe_lat;
    logic pf_lat;
    logic [3:0] pr_rdata;
    logic pr_rvalid;
    logic [3:0] pa_pu;
    logic [3:0] pb_out;
    logic [3:0] pb_oe;
    logic [3:0] pb_pu;
    logic [3:0] pc_out;
    logic [3:0] pc_oe;
    logic [3:0] pc_pu;
    logic [3:0] pd_out;
    logic [3:0] pd_oe;
    logic [3:0] pd_pu;
    logic [3:0] pe_out;
    logic [3:0] pe_oe;
    logic [3:0] pe_pu;
    logic pf_out;
    logic pf_oe;
    logic wake;
  } kio_top_state_t;

endpackage

/* hdl/kio_ports.sv */
// Notes on behaviour
// - writing the read-only input port changes nothing anywhere
// - unused control locations read a filler value; writes to them are dropped
// - port A: four inputs with pull-ups, read as pin levels
// - in standby, low on port A or input-mode B/C/D pins wakes
// - port B direction chosen per bit by its direction register
// - B/C/D outputs are open drain; output-mode reads return the latch
// - B/C/D pull-up on in input mode, off in output mode
// - reset puts all port B bits in input mode
// - port C switches direction as a group by one bit
// - port D switches as a group by a second bit, same nibble
// - reset puts ports C and D in output mode driving low
// - port E direction chosen per bit by its own register
// - port E data register; output-mode reads return the latch
// - port E pull-up per bit, kept even in output mode
// - reset puts all port E bits in input mode
// - port F direction fixed at build: input, or open drain with latch readback
// - port F never wakes the device from standby
// - port F pin is high impedance after reset
// - on switching to output, latch contents reach the pin at once
`timescale 1ns/1ps
`include "kio_map.svh"
module kio_ports
  import kio_pkg::*;
#(
  parameter bit PF_OUTPUT_MODE = 1'b0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register-file access
  input wire logic [5:0] i_rf_addr,
  input wire logic i_rf_wr,
  input wire logic i_rf_rd,
  input wire logic [3:0] i_rf_wdata,
  output logic [3:0] o_rf_rdata,
  output logic o_rf_rvalid,
  // port register access
  input wire logic i_pr_bank,
  input wire logic [6:0] i_pr_addr,
  input wire logic i_pr_wr,
  input wire logic i_pr_rd,
  input wire logic [3:0] i_pr_wdata,
  output logic [3:0] o_pr_rdata,
  output logic o_pr_rvalid,
  // standby
  input wire logic i_standby,
  output logic o_wake,
  // port A
  input wire logic [3:0] i_pa_pin,
  output logic [3:0] o_pa_pu,
  // port B
  input wire logic [3:0] i_pb_pin,
  output logic [3:0] o_pb_out,
  output logic [3:0] o_pb_oe,
  output logic [3:0] o_pb_pu,
  // port C
  input wire logic [3:0] i_pc_pin,
  output logic [3:0] o_pc_out,
  output logic [3:0] o_pc_oe,
  output logic [3:0] o_pc_pu,
  // port D
  input wire logic [3:0] i_pd_pin,
  output logic [3:0] o_pd_out,
  output logic [3:0] o_pd_oe,
  output logic [3:0] o_pd_pu,
  // port E
  input wire logic [3:0] i_pe_pin,
  output logic [3:0] o_pe_out,
  output logic [3:0] o_pe_oe,
  output logic [3:0] o_pe_pu,
  // port F
  input wire logic i_pf_pin,
  output logic o_pf_out,
  output logic o_pf_oe
);

  localparam kio_top_state_t ST_RST = '{
    pb_lat: `KIO_RST_PB_LAT, pc_lat: `KIO_RST_PC_LAT, pd_lat: `KIO_RST_PD_LAT,
    pe_lat: `KIO_RST_PE_LAT, pf_lat: `KIO_RST_PF_LAT,
    pr_rdata: 4'h0, pr_rvalid: 1'b0, pa_pu: 4'hF,
    pb_out: 4'h0, pb_oe: 4'h0, pb_pu: 4'hF,
    pc_out: 4'h0, pc_oe: 4'hF, pc_pu: 4'h0,
    pd_out: 4'h0, pd_oe: 4'hF, pd_pu: 4'h0,
    pe_out: `KIO_RST_PE_LAT, pe_oe: 4'h0, pe_pu: `KIO_RST_PE_PU,
    pf_out: 1'b0, pf_oe: 1'b0, wake: 1'b0};

  kio_top_state_t st_ff;
  kio_top_state_t nxt_st;
  logic [20:0] sync_q;
  logic [3:0] pa_s;
  logic [3:0] pb_s;
  logic [3:0] pc_s;
  logic [3:0] pd_s;
  logic [3:0] pe_s;
  logic pf_s;
  logic [3:0] pb_dir;
  logic [3:0] pe_dir;
  logic [3:0] pe_pu;
  logic [1:0] cd_grp;
  logic [3:0] pb_dir_n;
  logic [3:0] pe_dir_n;
  logic [3:0] pe_pu_n;
  logic [1:0] cd_grp_n;
  logic wake_cause;

  // =====================================================================
  // pin input filtering and control registers
  kio_sync #(
    .W(21)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d({i_pf_pin, i_pe_pin, i_pd_pin, i_pc_pin, i_pb_pin, i_pa_pin}),
    .o_q(sync_q)
  );

  assign pa_s = sync_q[3:0];
  assign pb_s = sync_q[7:4];
  assign pc_s = sync_q[11:8];
  assign pd_s = sync_q[15:12];
  assign pe_s = sync_q[19:16];
  assign pf_s = sync_q[20];

  kio_ctrl_regs u_regs (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_rf_addr(i_rf_addr),
    .i_rf_wr(i_rf_wr),
    .i_rf_rd(i_rf_rd),
    .i_rf_wdata(i_rf_wdata),
    .o_rf_rdata(o_rf_rdata),
    .o_rf_rvalid(o_rf_rvalid),
    .o_pb_dir(pb_dir),
    .o_pe_dir(pe_dir),
    .o_pe_pu(pe_pu),
    .o_cd_grp(cd_grp),
    .o_pb_dir_nxt(pb_dir_n),
    .o_pe_dir_nxt(pe_dir_n),
    .o_pe_pu_nxt(pe_pu_n),
    .o_cd_grp_nxt(cd_grp_n)
  );

  // port F can't wake: it is simply left out of the term
  assign wake_cause = (|(~pa_s)) | (|(~pb_s & ~pb_dir))
                    | (~cd_grp[0] & (|(~pc_s))) | (~cd_grp[1] & (|(~pd_s)));

  // =====================================================================
  // port latches, read path, pin drive
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pr_rvalid = 1'b0;
    // writes in input mode still load the latch, except port F in the input build; port A has none
    if (i_pr_wr)
    begin
      if (!i_pr_bank)
      begin
        if (i_pr_addr == `KIO_PR_PB)
          nxt_st.pb_lat = i_pr_wdata;
        else if (i_pr_addr == `KIO_PR_PC)
          nxt_st.pc_lat = i_pr_wdata;
        else if (i_pr_addr == `KIO_PR_PD)
          nxt_st.pd_lat = i_pr_wdata;
        else if (i_pr_addr == `KIO_PR_PE)
          nxt_st.pe_lat = i_pr_wdata;
      end
      else if ((i_pr_addr == `KIO_PR_PF) && PF_OUTPUT_MODE)
        nxt_st.pf_lat = i_pr_wdata[0];
    end
    if (i_pr_rd)
    begin
      nxt_st.pr_rvalid = 1'b1;
      nxt_st.pr_rdata = `KIO_UNUSED_RDATA;
      if (!i_pr_bank)
      begin
        if (i_pr_addr == `KIO_PR_PA)
          nxt_st.pr_rdata = pa_s;
        else if (i_pr_addr == `KIO_PR_PB)
          nxt_st.pr_rdata = (pb_dir & st_ff.pb_lat) | (~pb_dir & pb_s);
        else if (i_pr_addr == `KIO_PR_PC)
          nxt_st.pr_rdata = cd_grp[0] ? st_ff.pc_lat : pc_s;
        else if (i_pr_addr == `KIO_PR_PD)
          nxt_st.pr_rdata = cd_grp[1] ? st_ff.pd_lat : pd_s;
        else if (i_pr_addr == `KIO_PR_PE)
          nxt_st.pr_rdata = (pe_dir & st_ff.pe_lat) | (~pe_dir & pe_s);
      end
      else if (i_pr_addr == `KIO_PR_PF)
        nxt_st.pr_rdata = {3'b000, PF_OUTPUT_MODE ? st_ff.pf_lat : pf_s};
    end
    // drive follows the settings of this same edge, so a mode switch lands at once
    nxt_st.pa_pu = 4'hF;
    nxt_st.pb_out = 4'h0;
    nxt_st.pb_oe = pb_dir_n & ~nxt_st.pb_lat;
    nxt_st.pb_pu = ~pb_dir_n;
    nxt_st.pc_out = 4'h0;
    nxt_st.pc_oe = {4{cd_grp_n[0]}} & ~nxt_st.pc_lat;
    nxt_st.pc_pu = {4{~cd_grp_n[0]}};
    nxt_st.pd_out = 4'h0;
    nxt_st.pd_oe = {4{cd_grp_n[1]}} & ~nxt_st.pd_lat;
    nxt_st.pd_pu = {4{~cd_grp_n[1]}};
    nxt_st.pe_out = nxt_st.pe_lat;
    nxt_st.pe_oe = pe_dir_n;
    nxt_st.pe_pu = pe_pu_n;
    nxt_st.pf_out = 1'b0;
    nxt_st.pf_oe = PF_OUTPUT_MODE & ~nxt_st.pf_lat;
    nxt_st.wake = i_standby & wake_cause;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_ff <= ST_RST;
    else
      st_ff <= nxt_st;
  end

  assign o_pr_rdata = st_ff.pr_rdata;
  assign o_pr_rvalid = st_ff.pr_rvalid;
  assign o_wake = st_ff.wake;
  assign o_pa_pu = st_ff.pa_pu;
  assign o_pb_out = st_ff.pb_out;
  assign o_pb_oe = st_ff.pb_oe;
  assign o_pb_pu = st_ff.pb_pu;
  assign o_pc_out = st_ff.pc_out;
  assign o_pc_oe = st_ff.pc_oe;
  assign o_pc_pu = st_ff.pc_pu;
  assign o_pd_out = st_ff.pd_out;
  assign o_pd_oe = st_ff.pd_oe;
  assign o_pd_pu = st_ff.pd_pu;
  assign o_pe_out = st_ff.pe_out;
  assign o_pe_oe = st_ff.pe_oe;
  assign o_pe_pu = st_ff.pe_pu;
  assign o_pf_out = st_ff.pf_out;
  assign o_pf_oe = st_ff.pf_oe;

  // =====================================================================
  // checks
  logic first_ff;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      first_ff <= 1'b1;
    else
      first_ff <= 1'b0;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_ro_write;
    (i_pr_wr && !i_pr_bank && i_pr_addr == `KIO_PR_PA && !i_rf_wr)
      |=> $stable({st_ff.pb_lat, st_ff.pc_lat, st_ff.pd_lat, st_ff.pe_lat, st_ff.pf_lat});
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_unused_rf;
    (i_rf_wr && !i_pr_wr && i_rf_addr != `KIO_RF_PE_PU && i_rf_addr != `KIO_RF_PB_DIR
      && i_rf_addr != `KIO_RF_PE_DIR && i_rf_addr != `KIO_RF_CD_GRP)
      |=> $stable({pb_dir, pe_dir, pe_pu, cd_grp, o_pb_oe, o_pe_oe, o_pc_oe, o_pd_oe});
  endproperty
  a_unused_rf: assert property (p_unused_rf) else $error("unused location write took effect");

  property p_pa_read;
    (i_pr_rd && !i_pr_bank && i_pr_addr == `KIO_PR_PA) |=> o_pr_rvalid && o_pr_rdata == $past(pa_s);
  endproperty
  a_pa_read: assert property (p_pa_read) else $error("port A read is not the pin level");

  property p_wake;
    o_wake == $past(i_standby && wake_cause);
  endproperty
  a_wake: assert property (p_wake) else $error("wake does not follow standby and low pins");

  property p_b_drive;
    (i_rf_wr && i_rf_addr == `KIO_RF_PB_DIR)
      |=> o_pb_oe == ($past(i_rf_wdata) & ~st_ff.pb_lat) && o_pb_out == 4'h0
        && o_pb_pu == ~$past(i_rf_wdata);
  endproperty
  a_b_drive: assert property (p_b_drive) else $error("port B drive or pull-up wrong");

  property p_c_read;
    (i_pr_rd && !i_pr_bank && i_pr_addr == `KIO_PR_PC && cd_grp[0]) |=> o_pr_rdata == $past(st_ff.pc_lat);
  endproperty
  a_c_read: assert property (p_c_read) else $error("port C output-mode read not latch");

  property p_cd_group;
    (i_rf_wr && i_rf_addr == `KIO_RF_CD_GRP)
      |=> o_pc_oe == ({4{$past(i_rf_wdata[`KIO_CD_GRP_C_BIT])}} & ~st_ff.pc_lat)
        && o_pd_oe == ({4{$past(i_rf_wdata[`KIO_CD_GRP_D_BIT])}} & ~st_ff.pd_lat);
  endproperty
  a_cd_group: assert property (p_cd_group) else $error("port C or D not switching as a group");

  property p_reset_state;
    first_ff |-> o_pc_oe == 4'hF && o_pd_oe == 4'hF && o_pb_oe == 4'h0 && o_pe_oe == 4'h0 && !o_pf_oe;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("wrong pin state after reset");

  property p_e_drive;
    (i_rf_wr && i_rf_addr == `KIO_RF_PE_DIR)
      |=> o_pe_oe == $past(i_rf_wdata) && o_pe_out == st_ff.pe_lat;
  endproperty
  a_e_drive: assert property (p_e_drive) else $error("port E drive wrong");

  property p_e_pullup;
    (i_rf_wr && i_rf_addr == `KIO_RF_PE_PU) |=> o_pe_pu == $past(i_rf_wdata);
  endproperty
  a_e_pullup: assert property (p_e_pullup) else $error("port E pull-up wrong");

  property p_pf_input;
    !PF_OUTPUT_MODE |-> !o_pf_oe;
  endproperty
  a_pf_input: assert property (p_pf_input) else $error("input-only port F drives");

endmodule

/* hdl/kio_sync.sv */
`timescale 1ns/1ps
module kio_sync #(
  parameter int W = 21
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // raw pins and filtered levels
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } kio_sync_state_t;

  kio_sync_state_t st_ff;
  kio_sync_state_t nxt_st;

  generate
    if (W < 1)
    begin : g_chk
      $error("kio_sync: width must be at least one");
    end
  endgenerate

  // =====================================================================
  // three stages; a level counts once the last two agree
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.q = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
  end

  // pins idle high through their pull-ups, so reset to ones
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_ff <= '{s1: '1, s2: '1, s3: '1, q: '1};
    else
      st_ff <= nxt_st;
  end

  assign o_q = st_ff.q;

endmodule

/* sim/kio_pins_model.sv */
`timescale 1ns/1ps
// =====================================================================
// key matrix and lines: a pressed key pulls low, an undriven line floats
module kio_pins_model (
  // clock
  input wire logic i_clk,
  // drive from the port block
  input wire logic [3:0] i_pa_pu,
  input wire logic [3:0] i_pb_oe,
  input wire logic [3:0] i_pb_pu,
  input wire logic [3:0] i_pc_oe,
  input wire logic [3:0] i_pc_pu,
  input wire logic [3:0] i_pd_oe,
  input wire logic [3:0] i_pd_pu,
  input wire logic [3:0] i_pe_out,
  input wire logic [3:0] i_pe_oe,
  input wire logic [3:0] i_pe_pu,
  input wire logic i_pf_oe,
  // pressed keys: A 3:0, B 7:4, C 11:8, D 15:12, E 19:16, F 20
  input wire logic [20:0] i_key,
  // resolved pin levels
  output logic [3:0] o_pa,
  output logic [3:0] o_pb,
  output logic [3:0] o_pc,
  output logic [3:0] o_pd,
  output logic [3:0] o_pe,
  output logic o_pf
);
  // floating lines toggle every clock, so a missing pull-up reads as the level the synchroniser last held
  logic flt_ff = 1'b0;
  logic [3:0] flt;
  always_ff @(posedge i_clk) flt_ff <= ~flt_ff;
  assign flt = {4{flt_ff}};
  assign o_pa = ~i_key[3:0] & (i_pa_pu | flt);
  assign o_pb = ~(i_pb_oe | i_key[7:4]) & (i_pb_pu | flt);
  assign o_pc = ~(i_pc_oe | i_key[11:8]) & (i_pc_pu | flt);
  assign o_pd = ~(i_pd_oe | i_key[15:12]) & (i_pd_pu | flt);
  assign o_pe = (i_pe_oe & i_pe_out) | (~i_pe_oe & ~i_key[19:16] & (i_pe_pu | flt));
  assign o_pf = ~(i_pf_oe | i_key[20]) & flt_ff;
endmodule

/* sim/kio_ports_tb.sv */
`timescale 1ns/1ps
module kio_ports_tb;
  import kio_pkg::*;
  typedef struct packed {
    logic rf;
    logic wr;
    logic bank;
    logic [6:0] addr;
    logic [3:0] wd;
    logic [3:0] exp;
  } kio_row_t;
  // =====================================================================
  // stimulus and wiring
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [5:0] rf_addr = 6'h00;
  logic rf_wr = 1'b0;
  logic rf_rd = 1'b0;
  logic [3:0] rf_wdata = 4'h0;
  logic pr_bank = 1'b0;
  logic [6:0] pr_addr = 7'h00;
  logic pr_wr = 1'b0;
  logic pr_rd = 1'b0;
  logic [3:0] pr_wdata = 4'h0;
  logic standby = 1'b0;
  logic [20:0] key = 21'h0;
  logic [3:0] rf_rdata, pr_rdata, pa_pu, pa, pb, pc, pd, pe;
  logic [3:0] pb_out, pb_oe, pb_pu, pc_out, pc_oe, pc_pu, pd_out, pd_oe, pd_pu;
  logic [3:0] pe_out, pe_oe, pe_pu;
  logic rf_rvalid, pr_rvalid, wake, pf, pf_out, pf_oe;
  logic [3:0] f_pr_rdata;
  logic f_pf_oe;
  int failures = 0;
  int total_checks = 0;
  initial forever #10 i_clk = ~i_clk;
  kio_ports #(.PF_OUTPUT_MODE(1'b0)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_rf_addr(rf_addr), .i_rf_wr(rf_wr), .i_rf_rd(rf_rd), .i_rf_wdata(rf_wdata),
    .o_rf_rdata(rf_rdata), .o_rf_rvalid(rf_rvalid),
    .i_pr_bank(pr_bank), .i_pr_addr(pr_addr), .i_pr_wr(pr_wr), .i_pr_rd(pr_rd),
    .i_pr_wdata(pr_wdata), .o_pr_rdata(pr_rdata), .o_pr_rvalid(pr_rvalid),
    .i_standby(standby), .o_wake(wake), .i_pa_pin(pa), .o_pa_pu(pa_pu),
    .i_pb_pin(pb), .o_pb_out(pb_out), .o_pb_oe(pb_oe), .o_pb_pu(pb_pu),
    .i_pc_pin(pc), .o_pc_out(pc_out), .o_pc_oe(pc_oe), .o_pc_pu(pc_pu),
    .i_pd_pin(pd), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .o_pd_pu(pd_pu),
    .i_pe_pin(pe), .o_pe_out(pe_out), .o_pe_oe(pe_oe), .o_pe_pu(pe_pu),
    .i_pf_pin(pf), .o_pf_out(pf_out), .o_pf_oe(pf_oe)
  );
  // same stimulus, port F built as an open-drain output
  kio_ports #(.PF_OUTPUT_MODE(1'b1)) DUT_F (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_rf_addr(rf_addr), .i_rf_wr(rf_wr), .i_rf_rd(rf_rd), .i_rf_wdata(rf_wdata),
    .o_rf_rdata(), .o_rf_rvalid(),
    .i_pr_bank(pr_bank), .i_pr_addr(pr_addr), .i_pr_wr(pr_wr), .i_pr_rd(pr_rd),
    .i_pr_wdata(pr_wdata), .o_pr_rdata(f_pr_rdata), .o_pr_rvalid(),
    .i_standby(standby), .o_wake(), .i_pa_pin(pa), .o_pa_pu(),
    .i_pb_pin(pb), .o_pb_out(), .o_pb_oe(), .o_pb_pu(),
    .i_pc_pin(pc), .o_pc_out(), .o_pc_oe(), .o_pc_pu(),
    .i_pd_pin(pd), .o_pd_out(), .o_pd_oe(), .o_pd_pu(),
    .i_pe_pin(pe), .o_pe_out(), .o_pe_oe(), .o_pe_pu(),
    .i_pf_pin(pf), .o_pf_out(), .o_pf_oe(f_pf_oe)
  );
  kio_pins_model u_pins (
    .i_clk(i_clk), .i_pa_pu(pa_pu), .i_pb_oe(pb_oe), .i_pb_pu(pb_pu),
    .i_pc_oe(pc_oe), .i_pc_pu(pc_pu), .i_pd_oe(pd_oe), .i_pd_pu(pd_pu),
    .i_pe_out(pe_out), .i_pe_oe(pe_oe), .i_pe_pu(pe_pu), .i_pf_oe(pf_oe),
    .i_key(key), .o_pa(pa), .o_pb(pb), .o_pc(pc), .o_pd(pd), .o_pe(pe), .o_pf(pf)
  );
  // =====================================================================
  // ordinary accesses: rf, wr, bank, addr, wdata, expected read
  localparam int NROWS = 20;
  localparam kio_row_t ROWS [NROWS] = '{
    '{1'b1, 1'b0, 1'b0, 7'h26, 4'h0, 4'h0},
    '{1'b1, 1'b0, 1'b0, 7'h27, 4'h0, 4'h0},
    '{1'b1, 1'b0, 1'b0, 7'h37, 4'h0, 4'hC},
    '{1'b0, 1'b0, 1'b0, 7'h70, 4'h0, 4'hF},
    '{1'b0, 1'b0, 1'b0, 7'h72, 4'h0, 4'h0},
    '{1'b0, 1'b1, 1'b0, 7'h70, 4'h0, 4'h0},
    '{1'b0, 1'b0, 1'b0, 7'h70, 4'h0, 4'hF},
    '{1'b1, 1'b1, 1'b0, 7'h05, 4'hF, 4'h0},
    '{1'b1, 1'b0, 1'b0, 7'h05, 4'h0, 4'h0},
    '{1'b1, 1'b1, 1'b0, 7'h26, 4'h5, 4'h0},
    '{1'b1, 1'b0, 1'b0, 7'h26, 4'h0, 4'h5},
    '{1'b0, 1'b1, 1'b0, 7'h71, 4'h0, 4'h0},
    '{1'b0, 1'b0, 1'b0, 7'h71, 4'h0, 4'hA},
    '{1'b1, 1'b1, 1'b0, 7'h17, 4'hF, 4'h0},
    '{1'b1, 1'b1, 1'b0, 7'h27, 4'h3, 4'h0},
    '{1'b0, 1'b1, 1'b0, 7'h6F, 4'h2, 4'h0},
    '{1'b0, 1'b0, 1'b0, 7'h6F, 4'h0, 4'hE},
    '{1'b1, 1'b1, 1'b0, 7'h37, 4'h0, 4'h0},
    '{1'b0, 1'b0, 1'b0, 7'h72, 4'h0, 4'hF},
    '{1'b0, 1'b0, 1'b0, 7'h73, 4'h0, 4'hF}
  };
  // =====================================================================
  // shared tasks
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one access; reads are checked in the cycle of the answer pulse
  task automatic acc(input kio_row_t r);
    @(posedge i_clk);
    rf_addr <= r.addr[5:0];
    rf_wdata <= r.wd;
    pr_bank <= r.bank;
    pr_addr <= r.addr;
    pr_wdata <= r.wd;
    rf_wr <= r.rf & r.wr;
    rf_rd <= r.rf & ~r.wr;
    pr_wr <= ~r.rf & r.wr;
    pr_rd <= ~r.rf & ~r.wr;
    @(posedge i_clk);
    {rf_wr, rf_rd, pr_wr, pr_rd} <= 4'h0;
    #1;
    if (!r.wr)
    begin
      chk({3'h0, r.rf ? rf_rvalid : pr_rvalid}, 4'h1);
      chk(r.rf ? rf_rdata : pr_rdata, r.exp);
    end
    // pins need four edges through the synchroniser
    repeat (6) @(posedge i_clk);
  endtask
  task automatic wk(input logic [20:0] k, input logic exp);
    @(posedge i_clk);
    key <= k;
    repeat (8) @(posedge i_clk);
    #1;
    chk({3'h0, wake}, {3'h0, exp});
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    conclude();
  end
  // =====================================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < NROWS; i++)
      acc(ROWS[i]);
    #1;
    chk(pb_oe, 4'h5);
    chk(pb_pu, 4'hA);
    chk(pe_oe, 4'h3);
    chk(pe_out, 4'h2);
    chk(pe_pu, 4'hF);
    chk(pc_oe, 4'h0);
    chk(pd_pu, 4'hF);
    chk(pa_pu, 4'hF);
    chk(pb_out | pc_out | pd_out, 4'h0);
    chk({3'h0, pf_out}, 4'h0);
    // output-mode pull-up only goes when software clears it
    acc(kio_row_t'{1'b1, 1'b1, 1'b0, 7'h17, 4'h0, 4'h0});
    #1;
    chk(pe_pu, 4'h0);
    acc(kio_row_t'{1'b0, 1'b1, 1'b1, 7'h70, 4'h0, 4'h0});
    #1;
    chk({3'h0, pf_oe}, 4'h0);
    chk({3'h0, f_pf_oe}, 4'h1);
    acc(kio_row_t'{1'b0, 1'b0, 1'b0, 7'h50, 4'h0, 4'h0});
    standby <= 1'b1;
    wk(21'h100000, 1'b0);
    // key holds port F low: input build reads the pin, output build the latch
    acc(kio_row_t'{1'b0, 1'b1, 1'b1, 7'h70, 4'h1, 4'h0});
    acc(kio_row_t'{1'b0, 1'b0, 1'b1, 7'h70, 4'h0, 4'h0});
    #1;
    chk(f_pr_rdata, 4'h1);
    chk({3'h0, f_pf_oe}, 4'h0);
    acc(kio_row_t'{1'b0, 1'b1, 1'b1, 7'h70, 4'h0, 4'h0});
    wk(21'h000001, 1'b1);
    wk(21'h000200, 1'b1);
    wk(21'h000020, 1'b1);
    wk(21'h000000, 1'b0);
    acc(kio_row_t'{1'b1, 1'b1, 1'b0, 7'h37, 4'h4, 4'h0});
    #1;
    chk(pc_oe, 4'hF);
    wk(21'h000200, 1'b0);
    // latch released while a key pulls bit 1 low: read must give the latch
    acc(kio_row_t'{1'b0, 1'b1, 1'b0, 7'h72, 4'hF, 4'h0});
    acc(kio_row_t'{1'b0, 1'b0, 1'b0, 7'h72, 4'h0, 4'hF});
    // reset in mid-run
    @(posedge i_clk);
    standby <= 1'b0;
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(pb_oe, 4'h0);
    chk(pb_pu, 4'hF);
    chk(pc_oe & pd_oe, 4'hF);
    chk(pc_pu | pd_pu, 4'h0);
    chk(pe_oe, 4'h0);
    chk({3'h0, pf_oe}, 4'h0);
    chk({3'h0, f_pf_oe}, 4'h0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    acc(kio_row_t'{1'b1, 1'b0, 1'b0, 7'h37, 4'h0, 4'hC});
    acc(kio_row_t'{1'b0, 1'b0, 1'b0, 7'h73, 4'h0, 4'h0});
    conclude();
  end
endmodule
